// ==== bench/dmc_channel_tb_top.sv ====
// Self-checking bench of the DMA channel
`timescale 1ns/1ps
module dmc_channel_tb_top;
	import dmc_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic        ack;
	logic        sirq = 1'b0;
	logic        mreq, mwe, mack, irq;
	logic [23:0] maddr, last_wa;
	logic [31:0] mwdata, mrdata, last_wd, ctl;
	logic [3:0]  lat = 4'h0;
	logic [23:0] ss, ds;
	int          n_rd, n_wr, r0, w0;
	int          fail_count = 0;
	int          n_checks = 0;
	int          cycles = 0;

	dmc_channel DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.sync_irq_i(sirq), .mem_req_o(mreq), .mem_we_o(mwe),
		.mem_addr_o(maddr), .mem_wdata_o(mwdata), .mem_rdata_i(mrdata),
		.mem_ack_i(mack), .dma_irq_o(irq));
	dmc_mem_model mem (.clk_i(clk_i), .rst_i(rst_i), .lat_i(lat),
		.req_i(mreq), .we_i(mwe), .addr_i(maddr), .wdata_i(mwdata),
		.rdata_o(mrdata), .ack_o(mack), .n_rd_o(n_rd), .n_wr_o(n_wr),
		.last_wa_o(last_wa), .last_wd_o(last_wd));

	initial
	begin
		forever #2.5 clk_i = ~clk_i;
	end

	task automatic give_verdict;
		if (fail_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fail_count++;
			give_verdict;
		end
	end

	task automatic check(input string name, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, e, g);
		end
	endtask

	// Classic single cycle; request held until ack, then one idle cycle
	task automatic wb_acc(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s, output logic [31:0] q);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		do
		begin
			@(posedge clk_i);
		end
		while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb_acc(1'b1, a, d, 4'hf, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input string name);
		logic [31:0] q;
		wb_acc(1'b0, a, 32'h0, 4'h0, q);
		check(name, e, q);
	endtask

	task automatic pulse;
		sirq <= 1'b1;
		@(posedge clk_i);
		sirq <= 1'b0;
		repeat (20) @(posedge clk_i);
	endtask

	task automatic launch(input logic [23:0] s, input logic [23:0] d,
		input logic [23:0] c, input logic [31:0] k);
		wr(OFS_CTRL, 32'h0);
		wr(OFS_STAT, 32'h1);
		wr(OFS_SRC, {8'h0, s});
		wr(OFS_DST, {8'h0, d});
		wr(OFS_CNT, {8'h0, c});
		r0 = n_rd;
		w0 = n_wr;
		wr(OFS_CTRL, k | {30'h0, START_RUN});
	endtask

	task automatic wait_done;
		logic [31:0] q;
		int n;
		n = 0;
		q = 32'h0;
		while (q[B_DONE] !== 1'b1 && n < 100)
		begin
			wb_acc(1'b0, OFS_STAT, 32'h0, 4'h0, q);
			n++;
		end
	endtask

	function automatic logic [23:0] stp(input logic up, input logic dn);
		return (up && !dn) ? 24'h000001 : (dn && !up) ? 24'hffffff : 24'h0;
	endfunction

	initial
	begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(OFS_CTRL, 32'h0, "ctrl at reset");
		rd(OFS_CNT, 32'h0, "count at reset");
		check("irq at reset", 32'h0, {31'h0, irq});
		rd(8'h14, 32'h0, "unmapped read");
		wr(8'h14, 32'hffffffff);
		rd(OFS_CTRL, 32'h0, "ctrl after unmapped write");
		wb_acc(1'b1, OFS_SRC, 32'hffffffff, 4'h1, ctl);
		rd(OFS_SRC, 32'h000000ff, "src lane write");
		// Every pair of step controls, irq enable toggled, varied latency
		for (int i = 0; i < 4; i++)
		begin
			lat <= 4'(i);
			ctl = 32'h0;
			ctl[B_SRC_UP] = i[0];
			ctl[B_SRC_DN] = i[1];
			ctl[B_DST_UP] = i[1];
			ctl[B_DST_DN] = i[0];
			ctl[B_TC] = 1'b1;
			ctl[B_COUNT_ZERO_IRQ_ENABLE] = i[0];
			ss = stp(i[0], i[1]);
			ds = stp(i[1], i[0]);
			sirq <= 1'b1;
			launch(24'h000000, 24'h000100, 24'h000002, ctl);
			sirq <= 1'b0;
			wait_done;
			repeat (20) @(posedge clk_i);
			check("writes", 32'h2, n_wr - w0);
			rd(OFS_SRC, {8'h0, 24'(ss + ss)}, "src");
			rd(OFS_DST, {8'h0, 24'(24'h100 + ds + ds)}, "dst");
			check("wr addr", {8'h0, 24'(24'h100 + ds)}, {8'h0, last_wa});
			check("wr data", {8'h5a, ss}, last_wd);
			rd(OFS_CNT, 32'h0, "count");
			check("irq", {31'h0, i[0]}, {31'h0, irq});
		end
		// Source, destination and both-sides synchronization
		lat <= 4'h1;
		for (int m = 1; m < 4; m++)
		begin
			ctl = 32'h0;
			ctl[B_SYNC +: 2] = 2'(m);
			ctl[B_TC] = 1'b1;
			launch(24'h000020, 24'h000200, 24'h000001, ctl);
			repeat (20) @(posedge clk_i);
			check("reads held", m[0] ? 0 : 1, n_rd - r0);
			check("writes held", 32'h0, n_wr - w0);
			rd(OFS_CTRL, ctl | {28'h0, STAT_BUSY, START_RUN}, "stat");
			if (m == 2)
				wr(OFS_CTRL, ctl | {30'h0, START_XFER});
			pulse;
			check("reads one", 32'h1, n_rd - r0);
			check("writes one", m == 3 ? 0 : 1, n_wr - w0);
			pulse;
			check("writes two", 32'h1, n_wr - w0);
			check("sync data", 32'h5a000020, last_wd);
		end
		// Count zero does not stop the channel when the mode bit is clear
		lat <= 4'h0;
		ctl = 32'h0;
		ctl[B_COUNT_ZERO_IRQ_ENABLE] = 1'b1;
		launch(24'h000040, 24'h000300, 24'h000001, ctl);
		repeat (60) @(posedge clk_i);
		wr(OFS_CTRL, 32'h0);
		repeat (10) @(posedge clk_i);
		check("past zero", 32'h1, {31'h0, (n_wr - w0) > 1});
		rd(OFS_CNT, {8'h0, 24'(24'h1 - 24'(n_wr - w0))}, "wrap");
		check("irq mode 0", 32'h1, {31'h0, irq});
		rd(OFS_STAT, 32'h1, "status mode 0");
		give_verdict;
	end
endmodule // dmc_channel_tb_top

// ==== bench/dmc_mem_model.sv ====
// Memory target that answers channel accesses after a set delay
`timescale 1ns/1ps
module dmc_mem_model
	import dmc_pkg::*;
(
	input  wire logic                       clk_i,     // System clock
	input  wire logic                       rst_i,     // Sync reset
	input  wire logic [3:0]                 lat_i,     // Wait cycles
	input  wire logic                       req_i,     // Access held
	input  wire logic                       we_i,      // 1 write
	input  wire logic [dmc_pkg::ADDR_W-1:0] addr_i,    // Word address
	input  wire logic [dmc_pkg::DATA_W-1:0] wdata_i,   // Write data
	output logic [dmc_pkg::DATA_W-1:0]      rdata_o,   // Read data
	output logic                            ack_o,     // Access done
	output int                              n_rd_o,    // Reads served
	output int                              n_wr_o,    // Writes served
	output logic [dmc_pkg::ADDR_W-1:0]      last_wa_o, // Last write address
	output logic [dmc_pkg::DATA_W-1:0]      last_wd_o  // Last write data
);
	logic [3:0] wait_cnt;

	always_ff @(posedge clk_i)
	begin
		// Read data is only valid with ack; otherwise it keeps changing
		rdata_o <= ~rdata_o;
		if (rst_i)
		begin
			ack_o <= 1'b0;
			wait_cnt <= 4'h0;
			n_rd_o <= 0;
			n_wr_o <= 0;
			last_wa_o <= 24'h000000;
			last_wd_o <= 32'h00000000;
		end
		else if (ack_o)
		begin
			ack_o <= 1'b0;
			wait_cnt <= 4'h0;
		end
		else if (req_i && wait_cnt >= lat_i)
		begin
			ack_o <= 1'b1;
			if (we_i)
			begin
				n_wr_o <= n_wr_o + 1;
				last_wa_o <= addr_i;
				last_wd_o <= wdata_i;
			end
			else
			begin
				n_rd_o <= n_rd_o + 1;
				rdata_o <= {8'h5a, addr_i};
			end
		end
		else if (req_i)
		begin
			wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule // dmc_mem_model

// ==== src/dmc_channel.sv ====
// One DMA channel: control registers, transfer sequencer and memory master
//
// Behaviour
// R1: Step-up source control adds one per read
// R2: Step-down source control subtracts one per read
// R3: Equal source controls leave source unchanged
// R4: Step-up destination control adds one per write
// R5: Step-down destination control subtracts one per write
// R6: Equal destination controls leave destination unchanged
// R7: Sync 00 runs freely, ignores interrupts
// R8: Sync 01 holds each read for interrupt
// R9: Sync 10 holds each write for interrupt
// R10: Sync 11 waits interrupt before read, write
// R11: Mode 0 keeps transferring past count zero
// R12: Mode 1 stops when counter becomes zero
// R13: Count-zero interrupt enabled sets the flag
// R14: Disabled count-zero interrupt leaves flag alone
// R15: 24-bit addresses step after each access
// R16: Counter decrements at start of each write
// R17: Start bits 11 start or resume
// R18: After stopping, wait for new count
// R19: Controls reset to zero
`timescale 1ns/1ps
module dmc_channel
	import dmc_pkg::*;
(
	input  wire logic                       clk_i,       // 200 MHz clock
	input  wire logic                       rst_i,       // Sync reset
	input  wire logic                       wb_cyc_i,    // Bus cycle
	input  wire logic                       wb_stb_i,    // Bus strobe
	input  wire logic                       wb_we_i,     // Bus write
	input  wire logic [7:0]                 wb_adr_i,    // Byte address
	input  wire logic [3:0]                 wb_sel_i,    // Byte lanes
	input  wire logic [dmc_pkg::DATA_W-1:0] wb_dat_i,    // Write data
	output logic [dmc_pkg::DATA_W-1:0]      wb_dat_o,    // Read data
	output logic                            wb_ack_o,    // Bus ack
	input  wire logic                       sync_irq_i,  // Enabled irq
	output logic                            mem_req_o,   // Access held
	output logic                            mem_we_o,    // 1 write
	output logic [dmc_pkg::ADDR_W-1:0]      mem_addr_o,  // Word address
	output logic [dmc_pkg::DATA_W-1:0]      mem_wdata_o, // Write data
	input  wire logic [dmc_pkg::DATA_W-1:0] mem_rdata_i, // Read data
	input  wire logic                       mem_ack_i,   // Access done
	output logic                            dma_irq_o    // Count-zero flag
);
	import dmc_pkg::*;

	typedef struct packed {
		dmc_state_t          st;
		logic [1:0]          start;
		logic                src_addr_step_up;
		logic                src_addr_step_down;
		logic                dst_addr_step_up;
		logic                dst_addr_step_down;
		logic [1:0]          sync;
		logic                stop_on_count_zero;
		logic                count_zero_irq_enable;
		logic [ADDR_W-1:0]   src;
		logic [ADDR_W-1:0]   dst;
		logic [ADDR_W-1:0]   cnt;
		logic                irq_flag;
		logic                done;
		logic                wb_ack;
		logic [DATA_W-1:0]   wb_dat;
		logic                mem_req;
		logic                mem_we;
		logic [ADDR_W-1:0]   mem_addr;
		logic [DATA_W-1:0]   mem_wdata;
	} dmc_chan_t;

	dmc_chan_t         q;
	dmc_chan_t         next_q;
	logic              wb_hit;
	logic              wr_ctrl;
	logic              wr_src;
	logic              wr_dst;
	logic              wr_cnt;
	logic              wr_stat;
	logic [7:0]        reg_ofs;
	logic [DATA_W-1:0] ctrl_word;
	logic [1:0]        stat;
	logic              runnable;
	logic              rd_go;
	logic              wr_go;
	logic              rd_done;
	logic              wr_done;
	logic              buf_in_ready;
	logic              buf_out_valid;
	logic [DATA_W-1:0] buf_out_data;
	logic              buf_flush;
	logic              pend;
	logic              take;

	assign reg_ofs = {wb_adr_i[7:2], 2'b00};
	assign wb_hit  = wb_cyc_i && wb_stb_i && !q.wb_ack;
	assign wr_ctrl = wb_hit && wb_we_i && (reg_ofs == OFS_CTRL);
	assign wr_src  = wb_hit && wb_we_i && (reg_ofs == OFS_SRC);
	assign wr_dst  = wb_hit && wb_we_i && (reg_ofs == OFS_DST);
	assign wr_cnt  = wb_hit && wb_we_i && (reg_ofs == OFS_CNT);
	assign wr_stat = wb_hit && wb_we_i && (reg_ofs == OFS_STAT);

	assign rd_done = (q.st == ST_RD) && q.mem_req && mem_ack_i;
	assign wr_done = (q.st == ST_WR) && q.mem_req && mem_ack_i;

	// Run only while started and not parked at count zero
	assign runnable = (q.start == START_RUN) && !q.done && // R17 R18
		!(q.stop_on_count_zero && (q.cnt == RST_CNT)); // R12
	assign rd_go = (q.st == ST_IDLE) && runnable && buf_in_ready &&
		(!q.sync[0] || pend); // R7 R8 R10
	assign wr_go = (q.st == ST_WAIT) && q.start[1] && buf_out_valid &&
		(!q.sync[1] || pend); // R7 R9 R10
	assign take  = (rd_go && q.sync[0]) || (wr_go && q.sync[1]);
	assign buf_flush = (q.start == START_RESET) &&
		((q.st == ST_IDLE) || (q.st == ST_WAIT));

	always_comb
	begin
		stat = STAT_BUSY;
		case (q.st)
			ST_IDLE: stat = runnable ? STAT_BUSY : STAT_BETWEEN;
			ST_WAIT: stat = (q.start[1] && buf_out_valid) ?
				STAT_BUSY : STAT_MID;
			ST_RD:   stat = STAT_BUSY;
			ST_WR:   stat = STAT_BUSY;
			default: stat = STAT_BETWEEN;
		endcase
	end

	always_comb
	begin
		ctrl_word = '0;
		ctrl_word[B_START +: 2] = q.start;
		ctrl_word[B_STAT +: 2]  = stat;
		ctrl_word[B_SRC_UP]     = q.src_addr_step_up;
		ctrl_word[B_SRC_DN]     = q.src_addr_step_down;
		ctrl_word[B_DST_UP]     = q.dst_addr_step_up;
		ctrl_word[B_DST_DN]     = q.dst_addr_step_down;
		ctrl_word[B_SYNC +: 2]  = q.sync;
		ctrl_word[B_TC]         = q.stop_on_count_zero;
		ctrl_word[B_COUNT_ZERO_IRQ_ENABLE]      = q.count_zero_irq_enable;
	end

	dmc_fifo2 #(
		.W     (DATA_W),
		.DEPTH (BUF_DEPTH)
	) u_buf (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.flush_i     (buf_flush),
		.in_valid_i  (rd_done),
		.in_ready_o  (buf_in_ready),
		.in_data_i   (mem_rdata_i),
		.out_valid_o (buf_out_valid),
		.out_ready_i (wr_done),
		.out_data_o  (buf_out_data)
	);

	dmc_sync_latch u_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.on_i    (q.sync != SYNC_NONE),
		.event_i (sync_irq_i),
		.take_i  (take),
		.pend_o  (pend)
	);

	always_comb
	begin
		logic [DATA_W-1:0] m;
		logic              set_flag;
		m        = '0;
		set_flag = 1'b0;
		next_q   = q;
		next_q.wb_ack = 1'b0;

		// Transfer sequencer
		case (q.st)
			ST_IDLE:
			begin
				if (rd_go)
				begin
					next_q.st       = ST_RD;
					next_q.mem_req  = 1'b1;
					next_q.mem_we   = 1'b0;
					next_q.mem_addr = q.src;
				end
			end
			ST_RD:
			begin
				if (rd_done)
				begin
					next_q.mem_req = 1'b0;
					next_q.src = dmc_step(q.src, q.src_addr_step_up,
						q.src_addr_step_down); // R15
					next_q.st = (q.start == START_RESET) ?
						ST_IDLE : ST_WAIT;
				end
			end
			ST_WAIT:
			begin
				if (q.start == START_RESET)
				begin
					next_q.st = ST_IDLE;
				end
				else if (wr_go)
				begin
					next_q.st        = ST_WR;
					next_q.mem_req   = 1'b1;
					next_q.mem_we    = 1'b1;
					next_q.mem_addr  = q.dst;
					next_q.mem_wdata = buf_out_data;
					next_q.cnt       = q.cnt - 24'h000001; // R16 R11
					if (q.cnt == 24'h000001)
					begin
						set_flag    = q.count_zero_irq_enable; // R13 R14
						next_q.done = q.stop_on_count_zero; // R12 R18
					end
				end
			end
			ST_WR:
			begin
				if (wr_done)
				begin
					next_q.mem_req = 1'b0;
					next_q.mem_we  = 1'b0;
					next_q.dst = dmc_step(q.dst, q.dst_addr_step_up,
						q.dst_addr_step_down); // R15
					next_q.st = ST_IDLE;
				end
			end
			default:
			begin
				next_q.st      = ST_IDLE;
				next_q.mem_req = 1'b0;
			end
		endcase

		// Register slave; a software write to an address wins, but a same-cycle count-zero set beats a flag clear
		if (wb_hit)
		begin
			next_q.wb_ack = 1'b1;
			case (reg_ofs)
				OFS_CTRL: next_q.wb_dat = ctrl_word;
				OFS_SRC:  next_q.wb_dat = {8'h00, q.src};
				OFS_DST:  next_q.wb_dat = {8'h00, q.dst};
				OFS_CNT:  next_q.wb_dat = {8'h00, q.cnt};
				OFS_STAT: next_q.wb_dat = {30'h0, q.done, q.irq_flag};
				default:  next_q.wb_dat = '0;
			endcase
		end
		if (wr_ctrl)
		begin
			m = dmc_merge(ctrl_word, wb_dat_i, wb_sel_i);
			next_q.start                 = m[B_START +: 2];
			next_q.src_addr_step_up      = m[B_SRC_UP];
			next_q.src_addr_step_down    = m[B_SRC_DN];
			next_q.dst_addr_step_up      = m[B_DST_UP];
			next_q.dst_addr_step_down    = m[B_DST_DN];
			next_q.sync                  = m[B_SYNC +: 2];
			next_q.stop_on_count_zero    = m[B_TC];
			next_q.count_zero_irq_enable = m[B_COUNT_ZERO_IRQ_ENABLE];
		end
		if (wr_src)
		begin
			m          = dmc_merge({8'h00, q.src}, wb_dat_i, wb_sel_i);
			next_q.src = m[ADDR_W-1:0];
		end
		if (wr_dst)
		begin
			m          = dmc_merge({8'h00, q.dst}, wb_dat_i, wb_sel_i);
			next_q.dst = m[ADDR_W-1:0];
		end
		if (wr_cnt)
		begin
			m           = dmc_merge({8'h00, q.cnt}, wb_dat_i, wb_sel_i);
			next_q.cnt  = m[ADDR_W-1:0];
			next_q.done = 1'b0; // R18
		end
		if (wr_stat && wb_sel_i[0] && wb_dat_i[B_FLAG])
		begin
			next_q.irq_flag = 1'b0;
		end
		if (set_flag)
		begin
			next_q.irq_flag = 1'b1; // R13
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			q       <= '0; // R19
			q.st    <= ST_IDLE;
			q.start <= RST_START;
			q.sync  <= RST_SYNC;
			q.src   <= RST_ADDR;
			q.dst   <= RST_ADDR;
			q.cnt   <= RST_CNT;
		end
		else
		begin
			q <= next_q;
		end
	end

	assign wb_ack_o    = q.wb_ack;
	assign wb_dat_o    = q.wb_dat;
	assign mem_req_o   = q.mem_req;
	assign mem_we_o    = q.mem_we;
	assign mem_addr_o  = q.mem_addr;
	assign mem_wdata_o = q.mem_wdata;
	assign dma_irq_o   = q.irq_flag;

	sequence s_wr_start;
		(q.st == ST_WAIT) ##1 (q.st == ST_WR);
	endsequence

	property p_src_up;
		@(posedge clk_i) disable iff (rst_i)
		(rd_done && q.src_addr_step_up && !q.src_addr_step_down && !wr_src)
		|=> (q.src == $past(q.src) + 24'h000001);
	endproperty
	a_src_up: assert property (p_src_up) // R1
		else $error("source did not step up");

	property p_src_dn;
		@(posedge clk_i) disable iff (rst_i)
		(rd_done && q.src_addr_step_down && !q.src_addr_step_up && !wr_src)
		|=> (q.src == $past(q.src) - 24'h000001);
	endproperty
	a_src_dn: assert property (p_src_dn) // R2
		else $error("source did not step down");

	property p_src_hold;
		@(posedge clk_i) disable iff (rst_i)
		(rd_done && (q.src_addr_step_up == q.src_addr_step_down) && !wr_src)
		|=> $stable(q.src);
	endproperty
	a_src_hold: assert property (p_src_hold) // R3
		else $error("source changed with equal controls");

	property p_dst_up;
		@(posedge clk_i) disable iff (rst_i)
		(wr_done && q.dst_addr_step_up && !q.dst_addr_step_down && !wr_dst)
		|=> (q.dst == $past(q.dst) + 24'h000001);
	endproperty
	a_dst_up: assert property (p_dst_up) // R4
		else $error("destination did not step up");

	property p_dst_dn;
		@(posedge clk_i) disable iff (rst_i)
		(wr_done && q.dst_addr_step_down && !q.dst_addr_step_up && !wr_dst)
		|=> (q.dst == $past(q.dst) - 24'h000001);
	endproperty
	a_dst_dn: assert property (p_dst_dn) // R5
		else $error("destination did not step down");

	property p_dst_hold;
		@(posedge clk_i) disable iff (rst_i)
		(wr_done && (q.dst_addr_step_up == q.dst_addr_step_down) && !wr_dst)
		|=> $stable(q.dst);
	endproperty
	a_dst_hold: assert property (p_dst_hold) // R6
		else $error("destination changed with equal controls");

	property p_free_write;
		@(posedge clk_i) disable iff (rst_i)
		((q.sync == SYNC_NONE) && (q.st == ST_WAIT) &&
			(q.start == START_RUN) && buf_out_valid)
		|=> (q.st == ST_WR) && mem_req_o && mem_we_o;
	endproperty
	a_free_write: assert property (p_free_write) // R7
		else $error("free-running write held back");

	property p_src_sync;
		@(posedge clk_i) disable iff (rst_i)
		(q.sync[0] && (q.st == ST_IDLE) && !pend) |=> (q.st != ST_RD);
	endproperty
	a_src_sync: assert property (p_src_sync) // R8
		else $error("read started without interrupt");

	property p_dst_sync;
		@(posedge clk_i) disable iff (rst_i)
		(q.sync[1] && (q.st == ST_WAIT) && !pend) |=> (q.st != ST_WR);
	endproperty
	a_dst_sync: assert property (p_dst_sync) // R9 R10
		else $error("write started without interrupt");

	property p_cnt_dec;
		@(posedge clk_i) disable iff (rst_i)
		s_wr_start |-> (q.cnt == $past(q.cnt) - 24'h000001);
	endproperty
	a_cnt_dec: assert property (p_cnt_dec) // R16
		else $error("counter not decremented at write start");

	property p_zero_flag;
		@(posedge clk_i) disable iff (rst_i)
		(s_wr_start ##0 (q.cnt == RST_CNT) ##0
			$past(q.count_zero_irq_enable)) |-> q.irq_flag;
	endproperty
	a_zero_flag: assert property (p_zero_flag) // R13
		else $error("count-zero flag not set");

	property p_stop;
		@(posedge clk_i) disable iff (rst_i)
		(q.done && (q.st == ST_IDLE) && !wr_cnt) |=> (q.st == ST_IDLE)[*2];
	endproperty
	a_stop: assert property (p_stop) // R12 R18
		else $error("transfer issued after termination");

	property p_mem_hold;
		@(posedge clk_i) disable iff (rst_i)
		(mem_req_o && !mem_ack_i) |=> mem_req_o && $stable(mem_addr_o);
	endproperty
	a_mem_hold: assert property (p_mem_hold) // R15
		else $error("memory request dropped before ack");

endmodule // dmc_channel

// ==== src/dmc_fifo2.sv ====
// Small word buffer between the read and write phases
`timescale 1ns/1ps
module dmc_fifo2 #(
	parameter int W     = 32,
	parameter int DEPTH = 2
) (
	input  wire logic         clk_i,       // System clock
	input  wire logic         rst_i,       // Synchronous reset
	input  wire logic         flush_i,     // Drop all entries
	input  wire logic         in_valid_i,  // Word offered
	output logic              in_ready_o,  // Room for a word
	input  wire logic [W-1:0] in_data_i,   // Word in
	output logic              out_valid_o, // Word available
	input  wire logic         out_ready_i, // Word taken
	output logic [W-1:0]      out_data_o   // Word out
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0]           wp;
		logic [PW-1:0]           rp;
		logic [CW-1:0]           cnt;
	} dmc_fifo_t;

	dmc_fifo_t q;
	dmc_fifo_t next_q;
	logic      push;
	logic      pop;

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		if (p == PW'(DEPTH - 1))
		begin
			return '0;
		end
		return PW'(p + 1'b1);
	endfunction

	assign in_ready_o  = (q.cnt != CW'(DEPTH));
	assign out_valid_o = (q.cnt != '0);
	assign out_data_o  = q.mem[q.rp];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_ready_i && out_valid_o;

	always_comb
	begin
		next_q = q;
		if (flush_i)
		begin
			next_q.wp  = '0;
			next_q.rp  = '0;
			next_q.cnt = '0;
		end
		else
		begin
			if (push)
			begin
				next_q.mem[q.wp] = in_data_i;
				next_q.wp        = bump(q.wp);
			end
			if (pop)
			begin
				next_q.rp = bump(q.rp);
			end
			if (push && !pop)
			begin
				next_q.cnt = CW'(q.cnt + 1'b1);
			end
			else if (pop && !push)
			begin
				next_q.cnt = CW'(q.cnt - 1'b1);
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			q <= '0;
		end
		else
		begin
			q <= next_q;
		end
	end

endmodule // dmc_fifo2

// ==== src/dmc_pkg.sv ====
// Package: register map, field layout, encodings and helpers of the DMA channel
package dmc_pkg;

	localparam int ADDR_W    = 24;
	localparam int DATA_W    = 32;
	localparam int BUF_DEPTH = 2;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SRC  = 8'h04;
	localparam logic [7:0] OFS_DST  = 8'h08;
	localparam logic [7:0] OFS_CNT  = 8'h0c;
	localparam logic [7:0] OFS_STAT = 8'h10;

	// Control register field positions
	localparam int B_START  = 0;
	localparam int B_STAT   = 2;
	localparam int B_SRC_UP = 4;
	localparam int B_SRC_DN = 5;
	localparam int B_DST_UP = 6;
	localparam int B_DST_DN = 7;
	localparam int B_SYNC   = 8;
	localparam int B_TC     = 10;
	localparam int B_COUNT_ZERO_IRQ_ENABLE  = 11;

	// Status register field positions
	localparam int B_FLAG = 0;
	localparam int B_DONE = 1;

	// Values after reset
	localparam logic [1:0]        RST_START = 2'h0;
	localparam logic [1:0]        RST_SYNC  = 2'h0;
	localparam logic [ADDR_W-1:0] RST_ADDR  = 24'h000000;
	localparam logic [ADDR_W-1:0] RST_CNT   = 24'h000000;

	// Synchronization modes
	localparam logic [1:0] SYNC_NONE = 2'h0;
	localparam logic [1:0] SYNC_SRC  = 2'h1;
	localparam logic [1:0] SYNC_DST  = 2'h2;
	localparam logic [1:0] SYNC_BOTH = 2'h3;

	// Start control codes
	localparam logic [1:0] START_RESET = 2'h0;
	localparam logic [1:0] START_ACC   = 2'h1;
	localparam logic [1:0] START_XFER  = 2'h2;
	localparam logic [1:0] START_RUN   = 2'h3;

	// Status codes
	localparam logic [1:0] STAT_BETWEEN = 2'h0;
	localparam logic [1:0] STAT_MID     = 2'h1;
	localparam logic [1:0] STAT_BUSY    = 2'h3;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_RD   = 4'h2,
		ST_WAIT = 4'h4,
		ST_WR   = 4'h8
	} dmc_state_t;

	// Address stepping after an access
	function automatic logic [ADDR_W-1:0] dmc_step(
		input logic [ADDR_W-1:0] a,
		input logic              up,
		input logic              dn
	);
		if (up && !dn)
		begin
			return a + 24'h000001; // R1 R4
		end
		else if (dn && !up)
		begin
			return a - 24'h000001; // R2 R5
		end
		return a; // R3 R6
	endfunction

	// Byte-lane merge of a bus write
	function automatic logic [DATA_W-1:0] dmc_merge(
		input logic [DATA_W-1:0] old,
		input logic [DATA_W-1:0] wr,
		input logic [3:0]        sel
	);
		logic [DATA_W-1:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
			begin
				r[8*i +: 8] = wr[8*i +: 8];
			end
		end
		return r;
	endfunction

endpackage

// ==== src/dmc_sync_latch.sv ====
// Pending flag for one enabled synchronization interrupt
`timescale 1ns/1ps
module dmc_sync_latch (
	input  wire logic clk_i,   // System clock
	input  wire logic rst_i,   // Synchronous reset
	input  wire logic on_i,    // Synchronization mode active
	input  wire logic event_i, // Enabled interrupt pulse
	input  wire logic take_i,  // Pending event consumed
	output logic      pend_o   // Event waiting
);
	typedef struct packed {
		logic pend;
	} dmc_sync_t;

	dmc_sync_t q;
	dmc_sync_t next_q;

	assign pend_o = q.pend;

	always_comb
	begin
		next_q = q;
		// New event wins over a consume in the same cycle
		next_q.pend = (q.pend && !take_i) || event_i;
		if (!on_i)
		begin
			next_q.pend = 1'b0; // R7
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			q <= '0;
		end
		else
		begin
			q <= next_q;
		end
	end

endmodule // dmc_sync_latch
